// ===== rtl/lcd_base_dma_regs.vh
// Register map, field positions and encodings of the base layer DMA channel
`ifndef LCD_BASE_DMA_REGS_VH
`define LCD_BASE_DMA_REGS_VH
// ==========================================
// Register addresses (byte addresses)
`define ADDR_IRQ_ENABLE      32'hF803804C
`define ADDR_IRQ_DISABLE     32'hF8038050
`define ADDR_IRQ_MASK        32'hF8038054
`define ADDR_IRQ_STATUS      32'hF8038058
`define ADDR_DESC_HEAD       32'hF803805C
`define ADDR_FRAME_ADDRESS   32'hF8038060
`define ADDR_FETCH_CONTROL   32'hF8038064
`define ADDR_NEXT_DESC       32'hF8038068
`define ADDR_BUS_CONFIG      32'hF803806C
`define ADDR_PIXEL_FORMAT    32'hF8038070
`define ADDR_XFER_LENGTH     32'hF80380F0
`define ADDR_CHANNEL_START   32'hF80380F4
// ==========================================
// Reset value shared by every register
`define RESET_WORD           32'h00000000
// ==========================================
// Status / mask bit positions
`define BIT_XFER_END         2
`define BIT_DESC_LOADED      3
`define BIT_HEAD_LOADED      4
`define BIT_LIST_END         5
`define BIT_OVERFLOW         6
`define IRQ_LSB              2
`define IRQ_MSB              6
// ==========================================
// Fetch control fields
`define BIT_DESC_FETCH       0
`define BIT_LUT_FETCH        1
`define BIT_XFER_IRQ_OFF     2
`define BIT_DESC_IRQ_OFF     3
`define BIT_QUEUE_IRQ_OFF    4
`define BIT_LIST_IRQ_ON      5
`define CTRL_MSB             5
// ==========================================
// Bus config, pixel format, head, length and start fields
`define BURST_SEL_MSB        5
`define BURST_SEL_LSB        4
`define BIT_DEFINED_ONLY     8
`define BIT_LUT_SELECT       0
`define COLOUR_FMT_MSB       7
`define COLOUR_FMT_LSB       4
`define LUT_DEPTH_MSB        9
`define LUT_DEPTH_LSB        8
`define HEAD_ADDR_LSB        2
`define LEN_MSB              15
`define BIT_START            0
// ==========================================
// Burst length select codes
`define BURST_CODE_SINGLE    2'h0
`define BURST_CODE_FOUR      2'h1
`define BURST_CODE_EIGHT     2'h2
`define BURST_CODE_SIXTEEN   2'h3
// ==========================================
// AHB encodings
`define HTRANS_IDLE          2'h0
`define HTRANS_NONSEQ        2'h2
`define HTRANS_SEQ           2'h3
`define HBURST_SINGLE        3'h0
`define HBURST_INCR          3'h1
`define HBURST_INCR4         3'h3
`define HBURST_INCR8         3'h5
`define HBURST_INCR16        3'h7
`define HSIZE_WORD           3'h2
// ==========================================
// Channel states and sizes
`define ST_IDLE              2'h0
`define ST_DESC              2'h1
`define ST_LUT               2'h2
`define ST_DATA              2'h3
`define DESC_WORDS           16'h0003
`define FIFO_DEPTH           6'h20
`define WORD_STEP            32'h00000004
`define KB_WORDS             9'h100
`endif

// ===== rtl/lcd_base_layer_dma_channel.v
// Base display layer descriptor DMA channel with register slave and AHB master
//
// Strobed register access was left to the implementer.
`default_nettype none
`include "lcd_base_dma_regs.vh"

module lcd_base_layer_dma_channel
(
  input  wire        clk_sys,    // System bus clock
  input  wire        rstn,       // Asynchronous reset, active low
  input  wire [31:0] regAddr,    // Register byte address
  input  wire [31:0] regWdata,   // Register write data
  input  wire        regWrite,   // Write strobe
  input  wire        regRead,    // Read strobe
  output reg  [31:0] regRdata,   // Read data, cycle after strobe
  output wire        layerIrq,   // Layer interrupt request
  output reg  [31:0] HADDR,      // AHB address
  output reg  [1:0]  HTRANS,     // AHB transfer type
  output reg  [2:0]  HBURST,     // AHB burst type
  output wire [2:0]  HSIZE,      // AHB size, always word
  output wire        HWRITE,     // AHB direction, always read
  input  wire [31:0] HRDATA,     // AHB read data
  input  wire        HREADY,     // AHB ready
  input  wire        HRESP,      // AHB error response, unused
  output wire [31:0] pixData,    // Pixel word out of FIFO
  output wire        pixValid,   // Pixel word available
  input  wire        pixReady,   // Consumer takes the word
  input  wire [7:0]  lutIndex,   // Lookup table read index
  output reg  [31:0] lutData,    // Lookup table entry, registered
  output wire [3:0]  colourFmt,  // Direct colour format
  output wire [1:0]  lutDepth,   // Lookup depth code
  output wire        lutSelect   // Lookup table input selected
);

  // ==========================================
  // Registers
  reg  [6:0]  irqMask_r;      // Mask bits 6:2 used
  reg  [6:0]  irqStatus_r;    // Sticky status flags
  reg  [6:0]  irqStatus_nxt;
  reg  [31:0] head_r;         // Descriptor head pointer
  reg  [31:0] frameAddr_r;    // Frame / current transfer address
  reg  [5:0]  ctrl_r;         // Fetch control bits
  reg  [31:0] next_r;         // Next descriptor address
  reg  [1:0]  burstSel_r;     // Burst length select
  reg         definedOnly_r;  // Defined-length bursts only
  reg         lutSel_r;       // Lookup table input
  reg  [3:0]  colourFmt_r;    // Direct colour format
  reg  [1:0]  lutDepth_r;     // Lookup depth
  reg  [15:0] xferLen_r;      // Transfer length in words

  // Channel control
  reg  [1:0]  state_r;        // Channel state
  reg         fromHead_r;     // Current descriptor came from head
  reg         descMode_r;     // Channel runs a descriptor list
  reg  [31:0] busAddr_r;      // Next address to issue
  reg  [15:0] toIssue_r;      // Words of phase not yet launched
  reg  [15:0] wordsLeft_r;    // Words of phase not yet received
  reg  [15:0] rxCnt_r;        // Words received in this phase
  reg  [4:0]  beatsLeft_r;    // Address beats left in burst
  reg         firstBeat_r;    // Next beat is NONSEQ
  reg         dataPh_r;       // Data phase outstanding
  reg  [5:0]  pend_r;         // FIFO slots reserved by bursts
  reg  [31:0] descWord0_r;    // Descriptor address word

  // FIFO
  reg  [31:0] fifoMem [0:31]; // Pixel FIFO storage
  reg  [31:0] lutMem  [0:255];// Colour lookup table storage
  reg  [4:0]  wrPtr_r;
  reg  [4:0]  rdPtr_r;
  reg  [5:0]  count_r;

  // Event pulses and combinational helpers
  reg         evXferEnd;
  reg         evDescLoaded;
  reg         evHeadLoaded;
  reg         evListEnd;
  reg         evOverflow;
  reg  [15:0] cap;
  reg  [15:0] thresh;
  reg  [15:0] lim;
  reg  [15:0] room;
  reg  [15:0] toBound;
  reg  [4:0]  len;
  reg  [2:0]  burstType;
  reg         go;

  wire        burstBusy = (beatsLeft_r != 5'h00) | dataPh_r | (HTRANS != `HTRANS_IDLE);
  wire        beatIn    = HREADY & dataPh_r;
  wire        push      = beatIn & (state_r == `ST_DATA) & (count_r != `FIFO_DEPTH);
  wire        pop       = pixValid & pixReady;
  wire        phaseEnd  = (state_r != `ST_IDLE) & (toIssue_r == 16'h0000)
                          & (wordsLeft_r == 16'h0000) & ~burstBusy;
  wire        wrHit     = regWrite;
  wire        startReq  = regWrite & (regAddr == `ADDR_CHANNEL_START) & regWdata[`BIT_START];
  wire [15:0] lutWords  = 16'h0001 << (16'h0001 << lutDepth_r);
  // Per-source gates from control: inverted for bits 2-4, normal for bit 5
  wire [6:0]  ctrlGate  = {1'b1, ctrl_r[`BIT_LIST_IRQ_ON],
                           ~ctrl_r[`BIT_QUEUE_IRQ_OFF],
                           ~ctrl_r[`BIT_DESC_IRQ_OFF],
                           ~ctrl_r[`BIT_XFER_IRQ_OFF], 2'h0};

  assign HSIZE     = `HSIZE_WORD;
  assign HWRITE    = 1'b0;
  assign pixValid  = (count_r != 6'h00);
  assign pixData   = fifoMem[rdPtr_r];
  assign colourFmt = colourFmt_r;
  assign lutDepth  = lutDepth_r;
  assign lutSelect = lutSel_r;
  assign layerIrq  = |(irqStatus_r & irqMask_r & ctrlGate);

  // ==========================================
  // Burst choice: cap by select code, 1 KB boundary, room and remaining
  always @*
  begin
    case (burstSel_r)
      `BURST_CODE_FOUR:
      begin
        cap    = 16'd4;
        thresh = 16'd4;
      end
      `BURST_CODE_EIGHT:
      begin
        cap    = 16'd8;
        thresh = 16'd8;
      end
      `BURST_CODE_SIXTEEN:
      begin
        cap    = 16'd16;
        thresh = 16'd16;
      end
      default:
      begin
        cap    = 16'd16;
        thresh = 16'd1;
      end
    endcase
    // Room only limits pixel bursts; descriptor and table words skip the FIFO
    if (state_r == `ST_DATA)
      room = {10'h000, `FIFO_DEPTH - count_r - pend_r};
    else
      room = 16'hFFFF;
    // An AHB burst may not cross a 1 KB boundary
    toBound = {7'h00, `KB_WORDS - {1'b0, busAddr_r[9:2]}};
    lim = toIssue_r;
    if (room < lim)
      lim = room;
    if (toBound < lim)
      lim = toBound;
    if (cap < lim)
      lim = cap;
    // Wait for room for the threshold, or for the whole tail if shorter
    if (toIssue_r < thresh)
      go = (room >= toIssue_r);
    else
      go = (room >= thresh);
    go = go & (toIssue_r != 16'h0000) & ~burstBusy & (state_r != `ST_IDLE);
    if (lim >= 16'd16)
    begin
      len = 5'd16;
      burstType = `HBURST_INCR16;
    end
    else if (lim >= 16'd8)
    begin
      len = 5'd8;
      burstType = `HBURST_INCR8;
    end
    else if (lim >= 16'd4)
    begin
      len = 5'd4;
      burstType = `HBURST_INCR4;
    end
    else if ((lim >= 16'd2) && !definedOnly_r)
    begin
      len = lim[4:0];
      burstType = `HBURST_INCR;
    end
    else
    begin
      len = 5'd1;
      burstType = `HBURST_SINGLE;
    end
  end

  // ==========================================
  // Event detection from phase completion and from beats into a full FIFO
  always @*
  begin
    evXferEnd    = phaseEnd & (state_r == `ST_DATA);
    evDescLoaded = phaseEnd & (state_r == `ST_DESC);
    evHeadLoaded = evDescLoaded & fromHead_r;
    evListEnd    = evXferEnd & descMode_r & ~ctrl_r[`BIT_DESC_FETCH];
    evOverflow   = beatIn & (state_r == `ST_DATA) & (count_r == `FIFO_DEPTH);
  end

  // ==========================================
  // Status flags: read clears, a coincident event wins
  always @*
  begin
    irqStatus_nxt = irqStatus_r;
    if (regRead && (regAddr == `ADDR_IRQ_STATUS))
      irqStatus_nxt = 7'h00;
    irqStatus_nxt[`BIT_XFER_END]    = irqStatus_nxt[`BIT_XFER_END] | evXferEnd;
    irqStatus_nxt[`BIT_DESC_LOADED] = irqStatus_nxt[`BIT_DESC_LOADED] | evDescLoaded;
    irqStatus_nxt[`BIT_HEAD_LOADED] = irqStatus_nxt[`BIT_HEAD_LOADED] | evHeadLoaded;
    irqStatus_nxt[`BIT_LIST_END]    = irqStatus_nxt[`BIT_LIST_END] | evListEnd;
    irqStatus_nxt[`BIT_OVERFLOW]    = irqStatus_nxt[`BIT_OVERFLOW] | evOverflow;
  end

  // ==========================================
  // Register writes and read data
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irqMask_r     <= 7'h00;
      irqStatus_r   <= 7'h00;
      head_r        <= `RESET_WORD;
      burstSel_r    <= `BURST_CODE_SINGLE;
      definedOnly_r <= 1'b0;
      lutSel_r      <= 1'b0;
      colourFmt_r   <= 4'h0;
      lutDepth_r    <= 2'h0;
      xferLen_r     <= 16'h0000;
      regRdata      <= `RESET_WORD;
    end
    else
    begin
      irqStatus_r <= irqStatus_nxt;
      if (wrHit)
      begin
        case (regAddr)
          `ADDR_IRQ_ENABLE:
            irqMask_r[`IRQ_MSB:`IRQ_LSB] <= irqMask_r[`IRQ_MSB:`IRQ_LSB]
                                           | regWdata[`IRQ_MSB:`IRQ_LSB];
          `ADDR_IRQ_DISABLE:
            irqMask_r[`IRQ_MSB:`IRQ_LSB] <= irqMask_r[`IRQ_MSB:`IRQ_LSB]
                                           & ~regWdata[`IRQ_MSB:`IRQ_LSB];
          `ADDR_DESC_HEAD:
            head_r <= {regWdata[31:`HEAD_ADDR_LSB], 2'h0};
          `ADDR_BUS_CONFIG:
          begin
            burstSel_r    <= regWdata[`BURST_SEL_MSB:`BURST_SEL_LSB];
            definedOnly_r <= regWdata[`BIT_DEFINED_ONLY];
          end
          `ADDR_PIXEL_FORMAT:
          begin
            lutSel_r    <= regWdata[`BIT_LUT_SELECT];
            colourFmt_r <= regWdata[`COLOUR_FMT_MSB:`COLOUR_FMT_LSB];
            lutDepth_r  <= regWdata[`LUT_DEPTH_MSB:`LUT_DEPTH_LSB];
          end
          `ADDR_XFER_LENGTH:
            xferLen_r <= regWdata[`LEN_MSB:0];
          default:
            xferLen_r <= xferLen_r;   // Frame, control, next and start handled by the channel, others ignored
        endcase
      end
      // Unmapped or write-only addresses read as zero
      regRdata <= `RESET_WORD;
      if (regRead)
      begin
        case (regAddr)
          `ADDR_IRQ_MASK:      regRdata <= {25'h0, irqMask_r};
          `ADDR_IRQ_STATUS:    regRdata <= {25'h0, irqStatus_r};
          `ADDR_DESC_HEAD:     regRdata <= head_r;
          `ADDR_FRAME_ADDRESS: regRdata <= frameAddr_r;
          `ADDR_FETCH_CONTROL: regRdata <= {26'h0, ctrl_r};
          `ADDR_NEXT_DESC:     regRdata <= next_r;
          `ADDR_BUS_CONFIG:    regRdata <= {23'h0, definedOnly_r, 2'h0, burstSel_r, 4'h0};
          `ADDR_PIXEL_FORMAT:  regRdata <= {22'h0, lutDepth_r, colourFmt_r, 3'h0, lutSel_r};
          `ADDR_XFER_LENGTH:   regRdata <= {16'h0, xferLen_r};
          `ADDR_CHANNEL_START: regRdata <= {18'h0, count_r, 7'h00, (state_r != `ST_IDLE)};
          default:             regRdata <= `RESET_WORD;
        endcase
      end
    end
  end

  // ==========================================
  // Channel sequencer and AHB master
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r     <= `ST_IDLE;
      frameAddr_r <= `RESET_WORD;
      ctrl_r      <= 6'h00;
      next_r      <= `RESET_WORD;
      fromHead_r  <= 1'b0;
      descMode_r  <= 1'b0;
      busAddr_r   <= `RESET_WORD;
      toIssue_r   <= 16'h0000;
      wordsLeft_r <= 16'h0000;
      rxCnt_r     <= 16'h0000;
      beatsLeft_r <= 5'h00;
      firstBeat_r <= 1'b0;
      dataPh_r    <= 1'b0;
      pend_r      <= 6'h00;
      descWord0_r <= `RESET_WORD;
      HADDR       <= `RESET_WORD;
      HTRANS      <= `HTRANS_IDLE;
      HBURST      <= `HBURST_SINGLE;
    end
    else
    begin
      // Software writes reach these only while the channel is idle
      if (wrHit && (state_r == `ST_IDLE))
      begin
        if (regAddr == `ADDR_FRAME_ADDRESS)
          frameAddr_r <= regWdata;
        if (regAddr == `ADDR_FETCH_CONTROL)
          ctrl_r <= regWdata[`CTRL_MSB:0];
        if (regAddr == `ADDR_NEXT_DESC)
          next_r <= regWdata;
      end
      // Launch a burst, or move the one in flight
      if (go)
      begin
        beatsLeft_r <= len;
        firstBeat_r <= 1'b1;
        HBURST      <= burstType;
        toIssue_r   <= toIssue_r - {11'h000, len};
        if (state_r == `ST_DATA)
          pend_r <= pend_r + {1'b0, len};
      end
      else if (HREADY)
      begin
        // The address phase accepted at this edge owns the next data phase
        dataPh_r <= HTRANS[1];
        if (beatsLeft_r != 5'h00)
        begin
          HADDR       <= busAddr_r;
          HTRANS      <= firstBeat_r ? `HTRANS_NONSEQ : `HTRANS_SEQ;
          busAddr_r   <= busAddr_r + `WORD_STEP;
          beatsLeft_r <= beatsLeft_r - 5'h01;
          firstBeat_r <= 1'b0;
        end
        else
          HTRANS <= `HTRANS_IDLE;
        if (dataPh_r)
        begin
          wordsLeft_r <= wordsLeft_r - 16'h0001;
          rxCnt_r     <= rxCnt_r + 16'h0001;
          if (state_r == `ST_DATA)
            pend_r <= pend_r - 6'h01;
          if (state_r == `ST_DESC)
          begin
            // Descriptor: address, control, next
            case (rxCnt_r[1:0])
              2'h0:    descWord0_r <= HRDATA;
              2'h1:    ctrl_r <= HRDATA[`CTRL_MSB:0];
              default: next_r <= HRDATA;
            endcase
          end
        end
      end
      // Phase sequencing
      case (state_r)
        `ST_IDLE:
        begin
          if (startReq)
          begin
            rxCnt_r    <= 16'h0000;
            descMode_r <= ctrl_r[`BIT_DESC_FETCH];
            if (ctrl_r[`BIT_DESC_FETCH])
            begin
              state_r     <= `ST_DESC;
              fromHead_r  <= 1'b1;
              busAddr_r   <= head_r;
              toIssue_r   <= `DESC_WORDS;
              wordsLeft_r <= `DESC_WORDS;
            end
            else if (ctrl_r[`BIT_LUT_FETCH] && lutSel_r)
            begin
              state_r     <= `ST_LUT;
              busAddr_r   <= frameAddr_r;
              toIssue_r   <= lutWords;
              wordsLeft_r <= lutWords;
            end
            else if (xferLen_r != 16'h0000)
            begin
              state_r     <= `ST_DATA;
              busAddr_r   <= frameAddr_r;
              toIssue_r   <= xferLen_r;
              wordsLeft_r <= xferLen_r;
            end
          end
        end
        `ST_DESC:
        begin
          if (phaseEnd)
          begin
            frameAddr_r <= descWord0_r;
            fromHead_r  <= 1'b0;
            rxCnt_r     <= 16'h0000;
            busAddr_r   <= descWord0_r;
            if (ctrl_r[`BIT_LUT_FETCH] && lutSel_r)
            begin
              state_r     <= `ST_LUT;
              toIssue_r   <= lutWords;
              wordsLeft_r <= lutWords;
            end
            else
            begin
              state_r     <= `ST_DATA;
              toIssue_r   <= xferLen_r;
              wordsLeft_r <= xferLen_r;
            end
          end
        end
        `ST_LUT:
        begin
          // Table sits at the frame address, pixels follow it
          if (phaseEnd)
          begin
            state_r     <= `ST_DATA;
            rxCnt_r     <= 16'h0000;
            toIssue_r   <= xferLen_r;
            wordsLeft_r <= xferLen_r;
          end
        end
        `ST_DATA:
        begin
          if (phaseEnd)
          begin
            rxCnt_r <= 16'h0000;
            if (descMode_r && ctrl_r[`BIT_DESC_FETCH])
            begin
              state_r     <= `ST_DESC;
              busAddr_r   <= next_r;
              toIssue_r   <= `DESC_WORDS;
              wordsLeft_r <= `DESC_WORDS;
            end
            else
              state_r <= `ST_IDLE;
          end
        end
        default:
          state_r <= `ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Pixel FIFO pointers; a beat into a full FIFO is dropped
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr_r <= 5'h00;
      rdPtr_r <= 5'h00;
      count_r <= 6'h00;
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + 5'h01;
      if (pop)
        rdPtr_r <= rdPtr_r + 5'h01;
      if (push && !pop)
        count_r <= count_r + 6'h01;
      else if (pop && !push)
        count_r <= count_r - 6'h01;
    end
  end

  // ==========================================
  // Storage arrays, no reset needed
  always @(posedge clk_sys)
  begin
    if (push)
      fifoMem[wrPtr_r] <= HRDATA;
    if (beatIn && (state_r == `ST_LUT))
      lutMem[rxCnt_r[7:0]] <= HRDATA;
    lutData <= lutMem[lutIndex];
  end

endmodule
`default_nettype wire

// ===== test/lcd_base_layer_dma_channel_monitor.sv
// Checker for the base layer DMA channel, bound to its top module
`default_nettype none
`include "lcd_base_dma_regs.vh"
module lcd_dma_monitor
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        layerIrq,
  input wire logic [1:0]  HTRANS,
  input wire logic [2:0]  HBURST,
  input wire logic [3:0]  colourFmt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Burst settings as last written; writes there are never refused
  logic [8:0] cfgR;
  logic [3:0] fmtPrev;
  wire        nonseq = HTRANS == `HTRANS_NONSEQ;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      cfgR <= 9'h000;
    else if (regWrite && regAddr == `ADDR_BUS_CONFIG)
      cfgR <= regWdata[8:0];
  always_ff @(posedge clk_sys)
    fmtPrev <= regWdata[7:4];
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ==========================================
  // Register views and bus bursts
  AST_MASK_VIEW: assert property (regRead && regAddr == `ADDR_IRQ_MASK |=>
    regRdata[31:7] == 25'h0 && regRdata[1:0] == 2'h0) else $error("Mask stray bits");
  AST_STATUS_VIEW: assert property (regRead && regAddr == `ADDR_IRQ_STATUS |=>
    regRdata[31:7] == 25'h0 && regRdata[1:0] == 2'h0) else $error("Status stray bits");
  AST_HEAD_LOW: assert property (regRead && regAddr == `ADDR_DESC_HEAD |=>
    regRdata[1:0] == 2'h0) else $error("Head low bits set");
  AST_FMT_OUT: assert property (regWrite && regAddr == `ADDR_PIXEL_FORMAT |=>
    colourFmt == fmtPrev) else $error("Colour format not taken");
  AST_DEFINED_LENGTH_ONLY: assert property (nonseq && cfgR[8] |-> HBURST != `HBURST_INCR)
    else $error("Undefined burst in defined-only mode");
  AST_CAP_FOUR: assert property (nonseq && cfgR[5:4] == `BURST_CODE_FOUR |->
    HBURST inside {`HBURST_SINGLE, `HBURST_INCR, `HBURST_INCR4}) else $error("Over four");
  AST_CAP_EIGHT: assert property (nonseq && cfgR[5:4] == `BURST_CODE_EIGHT |->
    HBURST != `HBURST_INCR16) else $error("Over eight");
  AST_IRQ_OFF: assert property (regWrite && regAddr == `ADDR_IRQ_DISABLE &&
    regWdata[6:2] == 5'h1F |=> !layerIrq [*3]) else $error("Irq while all masked");
  cover property (nonseq && HBURST == `HBURST_INCR16);
  cover property (nonseq && cfgR[8]);
  cover property ($rose(layerIrq));
endmodule
bind lcd_base_layer_dma_channel lcd_dma_monitor lcd_dma_monitor_inst (.clk_sys, .rstn,
  .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .layerIrq, .HTRANS, .HBURST,
  .colourFmt);
`default_nettype wire

// ===== test/ahb_mem_model.sv
// System memory behind the bus, answering each read beat with an address pattern
`default_nettype none
module ahb_mem_model
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        slow,
  output logic      [31:0] HRDATA,
  output logic             HREADY
);
  timeunit 1ns;
  timeprecision 1ns;
  integer      pSeed = 32'h1C0FFEE5;
  logic        dataPh;
  logic        stallR;
  logic [31:0] phAddr;
  // Stalls only inside a data phase, so an idle bus is never held up
  assign HREADY = !(dataPh && slow && stallR);
  // Lines show the inverse pattern outside a valid beat, never a stale word
  assign HRDATA = (dataPh && HREADY) ? phAddr ^ 32'h5A5A0000 : ~(phAddr ^ 32'h5A5A0000);
  always @(posedge clk_sys or negedge rstn)
    if (!rstn)
      dataPh <= 1'b0;
    else
    begin
      stallR <= 1'($random(pSeed));
      if (HREADY)
      begin
        dataPh <= HTRANS[1];
        phAddr <= HADDR;
      end
    end
endmodule
`default_nettype wire

// ===== test/lcd_base_layer_dma_channel_tb.sv
// Self-checking bench for the base layer DMA channel
`default_nettype none
`include "lcd_base_dma_regs.vh"
module lcd_base_layer_dma_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] regAddr = 32'h0, regWdata = 32'h0;
  logic        regWrite = 1'b0, regRead = 1'b0, pixReady = 1'b0, slow = 1'b0, rdSeen = 1'b0;
  logic [7:0]  lutIndex = 8'h00;
  wire  [31:0] regRdata, HADDR, HRDATA, pixData;
  wire         layerIrq, HREADY, pixValid;
  wire  [1:0]  HTRANS;
  wire  [2:0]  HBURST;
  wire  [3:0]  colourFmt;
  integer      seed = 32'h65708631, badCount = 0, comparisons = 0, i, k, n;
  logic [31:0] expQ[$], pixQ[$], d, a;
  logic [31:0] adr[6] = '{`ADDR_DESC_HEAD, `ADDR_FRAME_ADDRESS, `ADDR_FETCH_CONTROL,
                          `ADDR_NEXT_DESC, `ADDR_BUS_CONFIG, `ADDR_PIXEL_FORMAT};
  logic [31:0] msk[6] = '{32'hFFFFFFFC, 32'hFFFFFFFF, 32'h0000003F, 32'hFFFFFFFC,
                          32'h00000130, 32'h000003F1};
  lcd_base_layer_dma_channel lcd_base_layer_dma_channel_inst (.clk_sys, .rstn, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .layerIrq, .HADDR, .HTRANS, .HBURST, .HSIZE(),
    .HWRITE(), .HRDATA, .HREADY, .HRESP(1'b0), .pixData, .pixValid, .pixReady, .lutIndex,
    .lutData(), .colourFmt, .lutDepth(), .lutSelect());
  ahb_mem_model ahb_mem_model_inst (.clk_sys, .rstn, .HADDR, .HTRANS, .slow, .HRDATA, .HREADY);
  initial
    forever #25 clk_sys = ~clk_sys;
  // ==========================================
  // Bus tasks and reporting
  task automatic bad(input string m);
    badCount++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic print_verdict();
    if (badCount == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
    @(posedge clk_sys);
    regAddr <= ad;
    regWdata <= dt;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] ex);
    expQ.push_back(ex);
    @(posedge clk_sys);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
  endtask
  task automatic irqIs(input logic ex);
    #1;
    comparisons++;
    if (layerIrq !== ex)
      bad("interrupt level");
  endtask
  // Bounded wait for every expected pixel word, then a few idle cycles
  task automatic drain();
    int j;
    for (j = 0; j < 3000 && pixQ.size() != 0; j++)
      @(posedge clk_sys);
    if (pixQ.size() != 0)
    begin
      bad("transfer did not finish");
      print_verdict();
    end
    repeat (4) @(posedge clk_sys);
  endtask
  // Consumer stalls at random; read data is looked at only in its one cycle
  always @(posedge clk_sys)
  begin
    pixReady <= 1'($random(seed));
    lutIndex <= 8'($random(seed));
  end
  always @(negedge clk_sys)
  begin
    if (rdSeen)
    begin
      comparisons++;
      if (expQ.size() == 0 || regRdata !== expQ.pop_front())
        bad("read data");
    end
    rdSeen = regRead;
    if (pixValid === 1'b1 && pixReady === 1'b1)
    begin
      comparisons++;
      if (pixQ.size() == 0 || pixData !== pixQ.pop_front())
        bad("pixel word");
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 8; i++)
      rd(`ADDR_IRQ_MASK + 32'(4 * i), `RESET_WORD);
    for (i = 0; i < 6; i++)
    begin
      d = $random(seed);
      wr(adr[i], (i == 3) ? d & msk[i] : d);
      rd(adr[i], d & msk[i]);
    end
    wr(`ADDR_IRQ_MASK, 32'hFFFFFFFF);
    rd(`ADDR_IRQ_MASK, 32'h0);
    rd(32'hF8038080, 32'h0);
    wr(`ADDR_IRQ_ENABLE, 32'hFFFFFFFF);
    rd(`ADDR_IRQ_MASK, 32'h0000007C);
    wr(`ADDR_IRQ_DISABLE, 32'h00000014);
    rd(`ADDR_IRQ_MASK, 32'h00000068);
    wr(`ADDR_IRQ_ENABLE, 32'h00000014);
    wr(`ADDR_PIXEL_FORMAT, 32'h0);
    wr(`ADDR_FETCH_CONTROL, 32'h0);
    // One frame per burst code, codes 1 to 3 crossing a 1 KB boundary, memory slow on odd codes
    for (k = 0; k < 4; k++)
    begin
      a = 32'h20000000 + 32'(k * 32'h3F0);
      n = 5 + 7 * k;
      slow <= k[0];
      wr(`ADDR_BUS_CONFIG, {23'h0, k[0], 2'h0, k[1:0], 4'h0});
      wr(`ADDR_FRAME_ADDRESS, a);
      wr(`ADDR_XFER_LENGTH, 32'(n));
      for (i = 0; i < n; i++)
        pixQ.push_back((a + 32'(4 * i)) ^ 32'h5A5A0000);
      wr(`ADDR_CHANNEL_START, 32'h1);
      drain();
      irqIs(1'b1);
      wr(`ADDR_FETCH_CONTROL, 32'h00000004);
      irqIs(1'b0);
      wr(`ADDR_FETCH_CONTROL, 32'h0);
      rd(`ADDR_IRQ_STATUS, 32'h00000004);
      rd(`ADDR_IRQ_STATUS, 32'h0);
      irqIs(1'b0);
    end
    // Descriptor at zero: its first word moves the frame, its control word ends the list
    wr(`ADDR_DESC_HEAD, 32'h0);
    wr(`ADDR_XFER_LENGTH, 32'h9);
    wr(`ADDR_FETCH_CONTROL, 32'h1);
    for (i = 0; i < 9; i++)
      pixQ.push_back(32'(4 * i));
    wr(`ADDR_CHANNEL_START, 32'h1);
    drain();
    irqIs(1'b1);
    rd(`ADDR_FRAME_ADDRESS, 32'h5A5A0000);
    rd(`ADDR_FETCH_CONTROL, 32'h00000004);
    rd(`ADDR_IRQ_STATUS, 32'h0000003C);
    irqIs(1'b0);
    wr(`ADDR_IRQ_DISABLE, 32'h0000007C);
    repeat (4) @(posedge clk_sys);
    print_verdict();
  end
endmodule
`default_nettype wire
